// >>> dv/axi_host_model.sv
// axi4-lite host model that drives the register port of the unit
`default_nettype none
module axi_host_model (
  input  wire logic        aclk,
  output logic      [7:0]  awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic      [7:0]  araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
    bready = 1'b1;
    rready = 1'b1;
  end
  // word offsets carry the 16-bit values high byte first
  // slow holds bready low so the response has to stand
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    input logic slow = 1'b0);
    if (slow)
      bready <= 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      // released data shows garbage, not the last word
      if (wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    if (slow)
    begin
      repeat (2) @(posedge aclk);
      bready <= 1'b1;
      @(posedge aclk);
    end
    r = bresp;
  endtask
  // slow holds rready low so the answer has to stand
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    input logic slow);
    if (slow)
      rready <= 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    if (slow)
    begin
      repeat (2) @(posedge aclk);
      rready <= 1'b1;
      @(posedge aclk);
    end
    d = rdata;
    r = rresp;
  endtask
endmodule // axi_host_model
`default_nettype wire

// >>> dv/opaddr_chk.sv
// protocol checker for the register port of the unit
`default_nettype none
module opaddr_chk (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bvalid_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped early");
  chk_rdata_stable: assert property (
    s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data moved while waiting");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  chk_ar_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  chk_aw_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after it was taken");
  chk_error_zero: assert property (
    s_axi_rvalid && s_axi_rresp == opaddr_pkg::resp_slverr |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
endmodule // opaddr_chk
bind operand_address_unit opaddr_chk chk (.*);
`default_nettype wire

// >>> dv/test_operand_address_unit.sv
// self-checking bench for the operand address unit
`default_nettype none
module test_operand_address_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          tries;
  logic [15:0] bases [3] = '{16'h1000, 16'h2000, 16'h3000};
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  operand_address_unit uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  axi_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // mode is stored first, go is a second write, then ea is read
  task automatic run(input logic [4:0] ctl, input logic [31:0] i0, input logic [31:0] i1);
    host.wr(opaddr_pkg::off_ins0, i0, resp);
    host.wr(opaddr_pkg::off_ins1, i1, resp);
    host.wr(opaddr_pkg::off_ctrl, {26'h0, ctl, 1'b0}, resp);
    host.wr(opaddr_pkg::off_ctrl, {26'h0, ctl, 1'b1}, resp);
    tries = 0;
    do
      host.rd(opaddr_pkg::off_status, rv, resp, 1'b0);
    while (rv[4] !== 1'b1 && tries++ < 20);
    host.rd(opaddr_pkg::off_ea, rv, resp, 1'b0);
  endtask
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    // whole sequence needs a few hundred cycles
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    host.rd(opaddr_pkg::off_ccr, rv, resp, 1'b1);
    chk(rv & 32'hff, 32'hd0);
    host.wr(opaddr_pkg::off_acc, 32'h12a5, resp, 1'b1);
    host.rd(opaddr_pkg::off_acc, rv, resp, 1'b1);
    chk(rv & 32'hffff, 32'h12a5);
    host.wr(opaddr_pkg::off_pc, 32'h1001, resp);
    run(5'h2, 32'h9642_0000, 32'h0);
    chk(rv, 32'h0042);
    host.rd(opaddr_pkg::off_pc, rv, resp, 1'b0);
    chk(rv & 32'hffff, 32'h1003);
    run(5'h2, 32'h1896_7700, 32'h0);
    chk(rv, 32'h0077);
    host.rd(opaddr_pkg::off_status, rv, resp, 1'b0);
    chk({31'h0, rv[6]}, 32'h1);
    run(5'h3, 32'hb612_3400, 32'h0);
    chk(rv, 32'h1234);
    host.wr(opaddr_pkg::off_pc, 32'h2000, resp);
    run(5'h4, 32'h2080_0000, 32'h0);
    chk(rv, 32'h1f82);
    run(5'h09, 32'h18c3_0000, 32'h0);
    chk(rv, 32'h2004);
    host.rd(opaddr_pkg::off_status, rv, resp, 1'b0);
    chk({29'h0, rv[2:0]}, 32'h4);
    run(5'h0, 32'h8700_0000, 32'h0);
    chk(rv, 32'h0);
    host.rd(opaddr_pkg::off_pc, rv, resp, 1'b0);
    chk(rv & 32'hffff, 32'h2007);
    host.wr(opaddr_pkg::off_ix, 32'hffff, resp);
    run(5'h5, 32'ha601_0000, 32'h0);
    chk(rv, 32'h0000);
    host.wr(opaddr_pkg::off_ix, 32'h1000, resp);
    host.wr(opaddr_pkg::off_iy, 32'h2000, resp);
    host.wr(opaddr_pkg::off_sp, 32'h3000, resp);
    for (int i = 0; i < 3; i++)
    begin
      run(5'h5, {8'ha6, i[1:0], 6'h10, 16'h0}, 32'h0);
      chk(rv, {16'h0, bases[i] - 16'h10});
    end
    run(5'h5, 32'ha6e6_0000, 32'h0);
    chk(rv, 32'h22a5);
    run(5'h5, 32'ha6e1_0000, 32'h0);
    chk(rv, 32'h0f00);
    run(5'h5, 32'ha6e2_8000, 32'h0);
    chk(rv, 32'h9000);
    host.wr(opaddr_pkg::off_ptr, 32'h4321, resp);
    chk({30'h0, resp}, {30'h0, opaddr_pkg::resp_okay});
    run(5'h5, 32'ha6e3_0010, 32'h0);
    chk(rv, 32'h4321);
    run(5'h5, 32'ha6b2_0000, 32'h0);
    chk(rv, 32'h3000);
    host.rd(opaddr_pkg::off_sp, rv, resp, 1'b0);
    chk(rv & 32'hffff, 32'h3003);
    host.rd(8'h30, rv, resp, 1'b1);
    chk({30'h0, resp}, {30'h0, opaddr_pkg::resp_slverr});
    host.wr(opaddr_pkg::off_ea, 32'h1, resp);
    chk({30'h0, resp}, {30'h0, opaddr_pkg::resp_slverr});
    end_of_test();
  end
endmodule // test_operand_address_unit
`default_nettype wire

// >>> hw/index_decode.sv
// decodes an indexed postbyte into base, offset and adjust
`default_nettype none
module index_decode (
  input  wire logic [7:0]  postbyte,
  input  wire logic [7:0]  ext1,
  input  wire logic [7:0]  ext2,
  input  wire logic [7:0]  acc_a,
  input  wire logic [7:0]  acc_b,
  output logic      [1:0]  base_sel,
  output logic      [15:0] offset,
  output logic             auto_adj,
  output logic             post_adj,
  output logic             indirect,
  output logic      [1:0]  ext_bytes,
  output logic             pc_illegal
);
  logic [15:0] dacc;
  assign dacc     = {acc_a, acc_b};

  always_comb
  begin
    offset     = 16'h0000;
    auto_adj   = 1'b0;
    post_adj   = 1'b0;
    indirect   = 1'b0;
    ext_bytes  = 2'h0;
    pc_illegal = 1'b0;
    base_sel   = postbyte[7:6];
    if (!postbyte[5])
    begin
      offset = {{11{postbyte[4]}}, postbyte[4:0]};
    end
    else if (postbyte[7:5] != 3'h7)
    begin
      // n = 0000 means +1, 1000 means -8
      auto_adj   = 1'b1;
      post_adj   = postbyte[4];
      offset     = postbyte[3] ? {{12{1'b1}}, postbyte[3:0]}
                               : {12'h000, postbyte[3:0]} + 16'h0001;
      pc_illegal = (postbyte[7:6] == opaddr_pkg::base_pc);
    end
    else
    begin
      base_sel = postbyte[4:3];
      if (!postbyte[2])
      begin
        if (!postbyte[1])
        begin
          offset    = {{8{postbyte[0]}}, ext1};
          ext_bytes = 2'h1;
        end
        else
        begin
          offset    = {ext1, ext2};
          ext_bytes = 2'h2;
          indirect  = postbyte[0];
        end
      end
      else
      begin
        unique case (postbyte[1:0])
          2'h0: offset = {8'h00, acc_a};
          2'h1: offset = {8'h00, acc_b};
          2'h2: offset = dacc;
          2'h3:
          begin
            offset   = dacc;
            indirect = 1'b1;
          end
        endcase
      end
    end
  end
endmodule // index_decode
`default_nettype wire

// >>> hw/opaddr_pkg.sv
// constants for the operand address unit
`default_nettype none
package opaddr_pkg;
  localparam logic [7:0]  page2_prefix = 8'h18;
  // base selector codes inside the postbyte
  localparam logic [1:0]  base_ix     = 2'h0;
  localparam logic [1:0]  base_iy     = 2'h1;
  localparam logic [1:0]  base_sp     = 2'h2;
  localparam logic [1:0]  base_pc     = 2'h3;
  localparam logic [15:0] sp_reset    = 16'h0000;
  localparam logic [15:0] pc_reset    = 16'h0000;
  localparam logic [7:0]  ccr_reset   = 8'hd0;
  localparam int          ccr_c       = 0;
  localparam int          ccr_v       = 1;
  localparam int          ccr_z       = 2;
  localparam int          ccr_n       = 3;
  localparam int          ccr_i       = 4;
  localparam int          ccr_h       = 5;
  localparam int          ccr_x       = 6;
  localparam int          ccr_s       = 7;
  // axi register offsets
  localparam logic [7:0]  off_ctrl    = 8'h00;
  localparam logic [7:0]  off_acc     = 8'h04;
  localparam logic [7:0]  off_ix      = 8'h08;
  localparam logic [7:0]  off_iy      = 8'h0c;
  localparam logic [7:0]  off_sp      = 8'h10;
  localparam logic [7:0]  off_pc      = 8'h14;
  localparam logic [7:0]  off_ccr     = 8'h18;
  localparam logic [7:0]  off_ins0    = 8'h1c;
  localparam logic [7:0]  off_ins1    = 8'h20;
  localparam logic [7:0]  off_ea      = 8'h24;
  localparam logic [7:0]  off_ptr     = 8'h28;
  localparam logic [7:0]  off_status  = 8'h2c;
  localparam logic [1:0]  resp_okay   = 2'h0;
  localparam logic [1:0]  resp_slverr = 2'h2;
  localparam int          queue_min   = 3;
  typedef enum logic [2:0] {
    mode_register_only = 3'h0,
    mode_literal       = 3'h1,
    mode_zero_page     = 3'h2,
    mode_full_address  = 3'h3,
    mode_pc_offset     = 3'h4,
    mode_indexed       = 3'h5
  } addr_mode_type;
endpackage
`default_nettype wire

// >>> hw/operand_address_unit.sv
// programmer register set and effective address unit with axi4-lite access
`default_nettype none
// What this block does
// - two 8-bit accumulators A and B
// - A and B combine into double accumulator
// - indexed address is index plus offset
// - stack pointer marks last used location
// - stack pointer valid in every indexed form
// - pointer register base except auto adjust
// - flags register: five flags, masks, stop bit
// - half carry decimal only; others for branches
// - words stored high byte first
// - no alignment needed, odd lengths allowed
// - queue holds eight bytes per instruction
// - register only mode fetches nothing
// - literal operand width set by instruction
// - zero page forces upper byte zero
// - full address mode takes 16-bit address
// - branch target is pointer plus offset
// - short indexed adds signed 5-bit constant
// - auto adjust by 1 to 8, pre/post
// - accumulator offset from A, B or D
// - nine bit offset uses one extension byte
// - sixteen bit offset uses two bytes
// - indirect forms fetch pointer as address
// - base selector 00 X 01 Y 10 SP 11 PC
// - page two only after 18 prefix
module operand_address_unit (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  logic [7:0]  acc_a_q;
  logic [7:0]  acc_b_q;
  logic [15:0] ix_q;
  logic [15:0] iy_q;
  logic [15:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0]  ccr_q;
  logic [31:0] ins0_q;
  logic [31:0] ins1_q;
  logic [15:0] ea_q;
  logic [15:0] ptr_q;
  logic [2:0]  len_q;
  logic        page2_q;
  logic        lit_wide_q;
  logic        rel_wide_q;
  logic        fault_q;
  logic        done_q;
  logic [2:0]  mode_q;
  logic        is_indirect_q;
  logic        fetch_go;

  // byte queue: byte 0 is opcode (or prefix); at least 3 bytes visible
  logic [7:0] qb [0:7];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_q
      assign qb[gi]     = ins0_q[31-8*gi -: 8];
      assign qb[gi + 4] = ins1_q[31-8*gi -: 8];
    end
  endgenerate

  logic       pfx;
  logic [2:0] opi;
  assign pfx = (qb[0] == opaddr_pkg::page2_prefix);
  assign opi = pfx ? 3'h2 : 3'h1;

  logic [7:0] pb;
  logic [7:0] e1;
  logic [7:0] e2;
  assign pb = qb[opi];
  assign e1 = qb[opi + 3'h1];
  assign e2 = qb[opi + 3'h2];

  logic [1:0]  ix_base;
  logic [15:0] ix_off;
  logic        ix_auto;
  logic        ix_post;
  logic        ix_ind;
  logic [1:0]  ix_ext;
  logic        ix_pcbad;

  index_decode u_dec (
    .postbyte   (pb),
    .ext1       (e1),
    .ext2       (e2),
    .acc_a      (acc_a_q),
    .acc_b      (acc_b_q),
    .base_sel   (ix_base),
    .offset     (ix_off),
    .auto_adj   (ix_auto),
    .post_adj   (ix_post),
    .indirect   (ix_ind),
    .ext_bytes  (ix_ext),
    .pc_illegal (ix_pcbad)
  );

  logic [15:0] base_val;
  always_comb
  begin
    unique case (ix_base)
      opaddr_pkg::base_ix: base_val = ix_q;
      opaddr_pkg::base_iy: base_val = iy_q;
      opaddr_pkg::base_sp: base_val = sp_q;
      opaddr_pkg::base_pc: base_val = pc_q;
    endcase
  end

  // operand bytes begin right after opcode; no alignment check on operand bytes
  logic [15:0] w_opnd;
  assign w_opnd = {pb, e1};

  logic [15:0] sum_ix;
  logic [15:0] ea_d;
  logic [2:0]  len_d;
  logic        ind_d;
  logic        fault_d;
  assign sum_ix = base_val + ix_off;

  always_comb
  begin
    ea_d    = 16'h0000;
    len_d   = opi;
    ind_d   = 1'b0;
    fault_d = 1'b0;
    unique case (opaddr_pkg::addr_mode_type'(mode_q))
      opaddr_pkg::mode_register_only: len_d = opi;
      opaddr_pkg::mode_literal:
      begin
        ea_d  = pc_q + {13'h0000, opi};
        len_d = opi + (lit_wide_q ? 3'h2 : 3'h1);
      end
      opaddr_pkg::mode_zero_page:
      begin
        ea_d  = {8'h00, pb};
        len_d = opi + 3'h1;
      end
      opaddr_pkg::mode_full_address:
      begin
        ea_d  = w_opnd;
        len_d = opi + 3'h2;
      end
      opaddr_pkg::mode_pc_offset:
      begin
        len_d = opi + (rel_wide_q ? 3'h2 : 3'h1);
        ea_d  = rel_wide_q ? pc_q + {13'h0000, len_d} + w_opnd
                           : pc_q + {13'h0000, len_d} + {{8{pb[7]}}, pb};
      end
      opaddr_pkg::mode_indexed:
      begin
        len_d   = opi + 3'h1 + {1'b0, ix_ext};
        ind_d   = ix_ind;
        fault_d = ix_auto & ix_pcbad;
        // pre adjust uses the moved register, post the old one
        ea_d    = (ix_auto & ix_post) ? base_val : sum_ix;
      end
      default: fault_d = 1'b1;
    endcase
  end

  // axi4-lite slave: both channels accepted once, response after both
  logic       aw_hold_q;
  logic       w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       wr_go;
  logic       wr_hit;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_go = aw_hold_q && w_hold_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= opaddr_pkg::resp_okay;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? opaddr_pkg::resp_okay : opaddr_pkg::resp_slverr;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = st[i] ? nw[8*i +: 8] : old[8*i +: 8];
  endfunction

  logic [31:0] acc_w;
  logic [31:0] ctrl_w;
  assign acc_w  = merge({16'h0000, acc_a_q, acc_b_q}, wdata_q, wstrb_q);
  assign ctrl_w = merge({26'h0, rel_wide_q, lit_wide_q, mode_q, 1'b0}, wdata_q, wstrb_q);
  assign wr_hit = awaddr_q[1:0] == 2'h0 &&
                  (awaddr_q <= opaddr_pkg::off_ins1 || awaddr_q == opaddr_pkg::off_ptr);
  assign fetch_go = wr_go && awaddr_q == opaddr_pkg::off_ctrl && ctrl_w[0];

  // register file: software loads state, bit 0 of ctrl runs one decode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc_a_q    <= 8'h00;
      acc_b_q    <= 8'h00;
      ix_q       <= 16'h0000;
      iy_q       <= 16'h0000;
      sp_q       <= opaddr_pkg::sp_reset;
      pc_q       <= opaddr_pkg::pc_reset;
      ccr_q      <= opaddr_pkg::ccr_reset;
      ins0_q     <= 32'h0000_0000;
      ins1_q     <= 32'h0000_0000;
      mode_q     <= 3'h0;
      lit_wide_q <= 1'b0;
      rel_wide_q <= 1'b0;
      ea_q       <= 16'h0000;
      len_q      <= 3'h0;
      page2_q    <= 1'b0;
      is_indirect_q <= 1'b0;
      fault_q    <= 1'b0;
      done_q     <= 1'b0;
    end
    else if (fetch_go)
    begin
      mode_q        <= ctrl_w[3:1];
      ea_q          <= ea_d;
      len_q         <= len_d;
      page2_q       <= pfx;
      is_indirect_q <= ind_d;
      fault_q       <= fault_d;
      done_q        <= 1'b1;
      if (!fault_d)
      begin
        pc_q <= pc_q + {13'h0000, len_d};
        if (mode_q == opaddr_pkg::mode_indexed && ix_auto)
        begin
          unique case (ix_base)
            opaddr_pkg::base_ix: ix_q <= sum_ix;
            opaddr_pkg::base_iy: iy_q <= sum_ix;
            opaddr_pkg::base_sp: sp_q <= sum_ix;
            opaddr_pkg::base_pc: pc_q <= pc_q + {13'h0000, len_d};
          endcase
        end
      end
    end
    else if (wr_go && wr_hit)
    begin
      unique case (awaddr_q)
        opaddr_pkg::off_ctrl:
        begin
          mode_q     <= ctrl_w[3:1];
          lit_wide_q <= ctrl_w[4];
          rel_wide_q <= ctrl_w[5];
          done_q     <= 1'b0;
        end
        opaddr_pkg::off_acc:
        begin
          acc_a_q <= acc_w[15:8];
          acc_b_q <= acc_w[7:0];
        end
        opaddr_pkg::off_ix:   ix_q   <= wdata_q[15:0];
        opaddr_pkg::off_iy:   iy_q   <= wdata_q[15:0];
        opaddr_pkg::off_sp:   sp_q   <= wdata_q[15:0];
        opaddr_pkg::off_pc:   pc_q   <= wdata_q[15:0];
        opaddr_pkg::off_ccr:  ccr_q  <= wdata_q[7:0];
        opaddr_pkg::off_ins0: ins0_q <= merge(ins0_q, wdata_q, wstrb_q);
        opaddr_pkg::off_ins1: ins1_q <= merge(ins1_q, wdata_q, wstrb_q);
        default: ;
      endcase
    end
  end

  // indirect pointer is delivered by software as the word at ea
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ptr_q <= 16'h0000;
    else if (wr_go && awaddr_q == opaddr_pkg::off_ptr)
      ptr_q <= wdata_q[15:0];
  end

  logic [31:0] rd_d;
  logic        rd_ok;
  logic [7:0]  branch_bits;
  // branch tests see n z v c only; h kept apart for decimal adjust
  assign branch_bits = {4'h0, ccr_q[opaddr_pkg::ccr_n], ccr_q[opaddr_pkg::ccr_z],
                        ccr_q[opaddr_pkg::ccr_v], ccr_q[opaddr_pkg::ccr_c]};
  always_comb
  begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      opaddr_pkg::off_ctrl:   rd_d = {26'h0, rel_wide_q, lit_wide_q, mode_q, 1'b0};
      opaddr_pkg::off_acc:    rd_d = {16'h0, acc_a_q, acc_b_q};
      opaddr_pkg::off_ix:     rd_d = {16'h0, ix_q};
      opaddr_pkg::off_iy:     rd_d = {16'h0, iy_q};
      opaddr_pkg::off_sp:     rd_d = {16'h0, sp_q};
      opaddr_pkg::off_pc:     rd_d = {16'h0, pc_q};
      opaddr_pkg::off_ccr:    rd_d = {16'h0, branch_bits, ccr_q};
      opaddr_pkg::off_ins0:   rd_d = ins0_q;
      opaddr_pkg::off_ins1:   rd_d = ins1_q;
      opaddr_pkg::off_ea:     rd_d = {16'h0, is_indirect_q ? ptr_q : ea_q};
      opaddr_pkg::off_ptr:    rd_d = {16'h0, ptr_q};
      opaddr_pkg::off_status: rd_d = {24'h0, is_indirect_q, page2_q, fault_q, done_q,
                                      1'b0, len_q};
      default:
      begin
        rd_d  = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= opaddr_pkg::resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rd_ok ? opaddr_pkg::resp_okay : opaddr_pkg::resp_slverr;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // operand_address_unit
`default_nettype wire
